// ### logic/mps_regs.svh
// offsets, fields, reset values and timing constants of the motor protection stages
// Overview of operation
// R1 - thermal mode sums squared current over time
// R2 - option starts sum above level; compare product
// R3 - start-up start reaches output one if routed
// R4 - start-up trip: indicator, code 6, held
// R5 - start-up level 1.0-10 In, 0.3-80 s
// R6 - latch option holds trip until reset
// R7 - five reset sources; three also erase records
// R8 - speed switch freezes start-up counting
// R9 - high-set start, timed trip, disable shows dashes
// R10 - high-set trip on output three, optionally two
// R11 - high-set level 0.5-20 In, 0.04-30 s
// R12 - high-set level doubles during starting situation
// R13 - earth stage: start, timed trip, code 7
// R14 - signalling-only earth keeps trip two off
// R15 - earth blocking input suppresses earth stage
// R16 - high phase current inhibits earth stage
// R17 - unbalance is max minus min over max
// R18 - divisor never below full load current
// R19 - inverse unbalance timer, one second at full
// R20 - unbalance trip: indicator, code 5, held
// R21 - unbalance blocking and enable options
// R22 - unbalance level 10-40 percent or infinite
// R23 - operate time falls linearly with unbalance
// R24 - timers tick together, clear when start drops
// R25 - standstill below 12 percent full load
`ifndef MPS_REGS_SVH
`define MPS_REGS_SVH
`define MPS_CLK_NS 10
`define MPS_TICK_NS 1000000
`define MPS_NS_PER_MS 1000000
`define MPS_WIN_MS 60
`define MPS_NSTG 4
`define MPS_STG_ST 0
`define MPS_STG_HS 1
`define MPS_STG_EF 2
`define MPS_STG_UB 3
`define MPS_A_SW 8'h00
`define MPS_A_FLC 8'h04
`define MPS_A_IS 8'h08
`define MPS_A_TS 8'h0c
`define MPS_A_HS 8'h10
`define MPS_A_HST 8'h14
`define MPS_A_EO 8'h18
`define MPS_A_EOT 8'h1c
`define MPS_A_UB 8'h20
`define MPS_A_UBT 8'h24
`define MPS_A_CMD 8'h28
`define MPS_A_STAT 8'h2c
`define MPS_A_REC 8'h30
`define MPS_CMD_KEEP 0
`define MPS_CMD_ERASE 1
`define MPS_SW_W 14
`define MPS_RST_SW 14'h1820
`define MPS_RST_FLC 16'h0064
`define MPS_RST_IS 20'h00258
`define MPS_RST_TS 20'h02710
`define MPS_RST_HS 20'h003e8
`define MPS_RST_HST 20'h00064
`define MPS_RST_EO 20'h00064
`define MPS_RST_EOT 20'h003e8
`define MPS_RST_UB 20'h00014
`define MPS_RST_UBT 20'h0ea60
`define MPS_IS_MIN 20'h00064
`define MPS_IS_MAX 20'h003e8
`define MPS_TS_MIN 20'h0012c
`define MPS_TS_MAX 20'h13880
`define MPS_HS_MIN 20'h00032
`define MPS_HS_MAX 20'h007d0
`define MPS_HST_MIN 20'h00028
`define MPS_HST_MAX 20'h07530
`define MPS_EO_MIN 20'h0000a
`define MPS_EO_MAX 20'h003e8
`define MPS_EOT_MIN 20'h00032
`define MPS_EOT_MAX 20'h07530
`define MPS_UB_LO 20'h0000a
`define MPS_UB_HI 20'h00028
`define MPS_UBT_MIN 20'h04e20
`define MPS_UBT_MAX 20'h1d4c0
`define MPS_PCT_FULL 10'h064
`define MPS_PCT_STILL 10'h00c
`define MPS_PCT_RISE 10'h096
`define MPS_PCT_END 10'h07d
`define MPS_PCT_HI4 10'h190
`define MPS_PCT_HI6 10'h258
`define MPS_PCT_HI8 10'h320
`define MPS_UB_MIN 32'h0000000a
`define MPS_UB_FULL 32'h00000064
`define MPS_UB_T1 32'h000003e8
`define MPS_DISP_UB 4'h5
`define MPS_DISP_ST 4'h6
`define MPS_DISP_EF 4'h7
`endif

// ### logic/mps_pkg.sv
// types shared by the motor protection stage logic
package mps_pkg;
   typedef struct packed {
      logic [15:0] la;
      logic [15:0] lb;
      logic [15:0] lc;
      logic [15:0] neu;
      logic speed;
      logic block;
      logic ext_rst;
      logic btn_rst;
      logic btn_prog;
      logic btn_step;
   } mps_pin_s;

   typedef struct packed {
      logic hs_to_ss2;
      logic earth_trip_route;
      logic unbal_enable;
      logic hicur_inhibit_sel_b;
      logic hicur_inhibit_sel_a;
      logic highset_doubling_en;
      logic highset_disable;
      logic startup_mode_select;
      logic stress_count_start_opt;
      logic start_route_sel;
      logic latch_opt_a;
      logic latch_opt_b;
      logic earth_block_en;
      logic unbal_block_en;
   } mps_sw_s;

   typedef enum logic [1:0] {SS_IDLE, SS_STILL, SS_RISE, SS_START} mps_ss_e;
endpackage

// ### logic/mps_top.sv
// start-up, high-set, earth-fault and unbalance protection stages
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "mps_regs.svh"
module mps_top
   import mps_pkg::*;
#(
   parameter int TICK_CYC = (`MPS_TICK_NS + `MPS_CLK_NS - 1) / `MPS_CLK_NS
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // measured currents
   input wire logic [15:0] phase_a_cur,
   input wire logic [15:0] phase_b_cur,
   input wire logic [15:0] phase_c_cur,
   input wire logic [15:0] neutral_cur,
   // control pins and front buttons
   input wire logic speed_switch,
   input wire logic blocking_input,
   input wire logic ext_reset_in,
   input wire logic reset_button,
   input wire logic program_button,
   input wire logic step_button,
   // relay outputs
   output logic signal_out_one,
   output logic signal_out_two,
   output logic signal_out_three,
   output logic trip_out_one,
   output logic trip_out_two,
   // front panel
   output logic [3:0] stage_start,
   output logic [3:0] indicator,
   output logic [3:0] display_code
);

   localparam logic [7:0] WIN_TK = 8'(`MPS_WIN_MS * `MPS_NS_PER_MS / `MPS_TICK_NS);

   mps_pin_s pin_d;
   mps_pin_s pin_m_q;
   mps_pin_s pin_q;
   mps_pin_s pin_p_q;
   mps_sw_s sw_q;
   logic [15:0] flc_q;
   logic [19:0] is_q;
   logic [19:0] ts_q;
   logic [19:0] hs_q;
   logic [19:0] hst_q;
   logic [19:0] eo_q;
   logic [19:0] eot_q;
   logic [19:0] ub_q;
   logic [19:0] ubt_q;
   logic cmd_keep_q;
   logic cmd_erase_q;
   logic [31:0] tick_cnt_q;
   logic tick_q;
   mps_ss_e ss_q;
   logic [7:0] win_q;
   logic [59:0] acc_q;
   logic [59:0] lim;
   logic [31:0] sq;
   logic [19:0] tmr_q [`MPS_NSTG];
   logic [19:0] tgt [`MPS_NSTG];
   logic [`MPS_NSTG-1:0] st;
   logic [`MPS_NSTG-1:0] hold;
   logic [`MPS_NSTG-1:0] op;
   logic [`MPS_NSTG-1:0] lat;
   logic [`MPS_NSTG-1:0] ind_set;
   logic [`MPS_NSTG-1:0] tr_q;
   logic [`MPS_NSTG-1:0] ind_q;
   logic [7:0] trips_q;
   logic [15:0] imax;
   logic [15:0] imin;
   logic [15:0] denom;
   logic [19:0] hs_lvl;
   logic [31:0] unum;
   logic [31:0] upct;
   logic [31:0] ubase;
   logic [31:0] uspan;
   logic [31:0] ustep;
   logic [31:0] utgt;
   logic still;
   logic rise;
   logic fall;
   logic hicur;
   logic eblk;
   logic uen;
   logic acc_run;
   logic prog_rise;
   logic rbtn_rise;
   logic ext_rise;
   logic rst_keep;
   logic rst_erase;
   logic trip_clr;
   logic ind_clr;

   function automatic logic [19:0] clamp(input logic [19:0] v, input logic [19:0] lo, input logic [19:0] hi);
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   function automatic logic [31:0] sc(input logic [15:0] x, input logic [9:0] p);
      sc = {16'h0000, x} * {22'h000000, p};
   endfunction

   // pin synchroniser, plus one more stage for edge detection
   assign pin_d = {phase_a_cur, phase_b_cur, phase_c_cur, neutral_cur, speed_switch,
                   blocking_input, ext_reset_in, reset_button, program_button, step_button};

   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
      begin
         pin_m_q <= '0;
         pin_q <= '0;
         pin_p_q <= '0;
      end
      else
      begin
         pin_m_q <= pin_d;
         pin_q <= pin_m_q;
         pin_p_q <= pin_q;
      end

   // setting registers, all but the switch and full load registers clamped to their ranges on write
   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
      begin
         sw_q <= `MPS_RST_SW;
         flc_q <= `MPS_RST_FLC;
         is_q <= `MPS_RST_IS;
         ts_q <= `MPS_RST_TS;
         hs_q <= `MPS_RST_HS;
         hst_q <= `MPS_RST_HST;
         eo_q <= `MPS_RST_EO;
         eot_q <= `MPS_RST_EOT;
         ub_q <= `MPS_RST_UB;
         ubt_q <= `MPS_RST_UBT;
      end
      else if (wr)
      begin
         case (addr)
            `MPS_A_SW: sw_q <= wdata[`MPS_SW_W-1:0];
            `MPS_A_FLC: flc_q <= wdata[15:0];
            `MPS_A_IS: is_q <= clamp(wdata[19:0], `MPS_IS_MIN, `MPS_IS_MAX); // [R5]
            `MPS_A_TS: ts_q <= clamp(wdata[19:0], `MPS_TS_MIN, `MPS_TS_MAX); // [R5]
            `MPS_A_HS: hs_q <= clamp(wdata[19:0], `MPS_HS_MIN, `MPS_HS_MAX); // [R11]
            `MPS_A_HST: hst_q <= clamp(wdata[19:0], `MPS_HST_MIN, `MPS_HST_MAX); // [R11]
            `MPS_A_EO: eo_q <= clamp(wdata[19:0], `MPS_EO_MIN, `MPS_EO_MAX); // [R13]
            `MPS_A_EOT: eot_q <= clamp(wdata[19:0], `MPS_EOT_MIN, `MPS_EOT_MAX); // [R13]
            `MPS_A_UB: ub_q <= (wdata[19:0] == 20'h0) ? 20'h0 : clamp(wdata[19:0], `MPS_UB_LO, `MPS_UB_HI); // [R22]
            `MPS_A_UBT: ubt_q <= clamp(wdata[19:0], `MPS_UBT_MIN, `MPS_UBT_MAX); // [R22]
            default: ;
         endcase
      end

   // remote reset commands, one-cycle pulses
   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
      begin
         cmd_keep_q <= 1'b0;
         cmd_erase_q <= 1'b0;
      end
      else
      begin
         cmd_keep_q <= wr && addr == `MPS_A_CMD && wdata[`MPS_CMD_KEEP];
         cmd_erase_q <= wr && addr == `MPS_A_CMD && wdata[`MPS_CMD_ERASE];
      end

   // reset sources
   assign prog_rise = pin_q.btn_prog & ~pin_p_q.btn_prog;
   assign rbtn_rise = pin_q.btn_rst & ~pin_p_q.btn_rst;
   assign ext_rise = pin_q.ext_rst & ~pin_p_q.ext_rst;
   assign rst_keep = (prog_rise & ~pin_q.btn_step) | cmd_keep_q; // [R7]
   assign rst_erase = (prog_rise & pin_q.btn_step) | cmd_erase_q | ext_rise; // [R7]
   assign trip_clr = rst_keep | rst_erase; // [R7]
   assign ind_clr = rbtn_rise | trip_clr; // [R4]

   // common sampling tick
   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
      begin
         tick_cnt_q <= '0;
         tick_q <= 1'b0;
      end
      else
      begin
         tick_q <= (tick_cnt_q == 32'(TICK_CYC - 1)); // [R24]
         tick_cnt_q <= (tick_cnt_q == 32'(TICK_CYC - 1)) ? 32'h0 : tick_cnt_q + 32'h1;
      end

   // phase extremes and current levels
   always_comb
   begin
      imax = pin_q.la;
      if (pin_q.lb > imax)
         imax = pin_q.lb;
      if (pin_q.lc > imax)
         imax = pin_q.lc;
      imin = pin_q.la;
      if (pin_q.lb < imin)
         imin = pin_q.lb;
      if (pin_q.lc < imin)
         imin = pin_q.lc;
   end

   assign still = sc(imax, `MPS_PCT_FULL) < sc(flc_q, `MPS_PCT_STILL); // [R25]
   assign rise = sc(imax, `MPS_PCT_FULL) > sc(flc_q, `MPS_PCT_RISE);
   assign fall = sc(imax, `MPS_PCT_FULL) < sc(flc_q, `MPS_PCT_END);

   // starting situation detector
   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
         ss_q <= SS_IDLE;
      else
      begin
         unique case (ss_q)
            SS_IDLE:
               if (still)
                  ss_q <= SS_STILL;
            SS_STILL:
               if (rise)
                  ss_q <= SS_START; // [R12]
               else if (!still)
                  ss_q <= SS_RISE;
            SS_RISE:
               if (rise)
                  ss_q <= SS_START; // [R12]
               else if (still)
                  ss_q <= SS_STILL;
               else if (win_q >= WIN_TK)
                  ss_q <= SS_IDLE; // [R12]
            SS_START:
               if (still)
                  ss_q <= SS_STILL;
               else if (fall)
                  ss_q <= SS_IDLE; // [R12]
         endcase
      end

   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
         win_q <= '0;
      else if (ss_q != SS_RISE)
         win_q <= '0;
      else if (tick_q && win_q < WIN_TK)
         win_q <= win_q + 8'h01; // [R12]

   // unbalance degree and inverse operate time
   always_comb
   begin
      denom = (imax < flc_q) ? flc_q : imax; // [R18]
      unum = {16'h0000, imax - imin} * 32'h00000064;
      upct = (denom == 16'h0000) ? 32'h0 : unum / {16'h0000, denom}; // [R17]
      ubase = {12'h000, ubt_q};
      uspan = ubase - `MPS_UB_T1;
      ustep = (upct > `MPS_UB_MIN) ? upct - `MPS_UB_MIN : 32'h0;
      utgt = (upct >= `MPS_UB_FULL) ? `MPS_UB_T1 : ubase - (uspan * ustep) / (`MPS_UB_FULL - `MPS_UB_MIN); // [R19] [R23]
   end

   // earth-fault high-current inhibit
   always_comb
   begin
      unique case ({sw_q.hicur_inhibit_sel_b, sw_q.hicur_inhibit_sel_a})
         2'b00: hicur = 1'b0;
         2'b01: hicur = sc(imax, `MPS_PCT_FULL) > sc(flc_q, `MPS_PCT_HI4); // [R16]
         2'b10: hicur = sc(imax, `MPS_PCT_FULL) > sc(flc_q, `MPS_PCT_HI6); // [R16]
         2'b11: hicur = sc(imax, `MPS_PCT_FULL) > sc(flc_q, `MPS_PCT_HI8); // [R16]
      endcase
   end

   // stage start conditions and timer targets
   assign hs_lvl = (sw_q.highset_doubling_en && ss_q == SS_START) ? {hs_q[18:0], 1'b0} : hs_q; // [R12]
   assign eblk = (sw_q.earth_block_en & pin_q.block) | hicur; // [R15] [R16]
   assign uen = sw_q.unbal_enable & (ub_q != 20'h0) & ~(sw_q.unbal_block_en & pin_q.block); // [R21] [R22]

   always_comb
   begin
      st = '0;
      hold = '0;
      st[`MPS_STG_ST] = {4'h0, imax} > is_q;
      st[`MPS_STG_HS] = ~sw_q.highset_disable & ({4'h0, imax} > hs_lvl); // [R9]
      st[`MPS_STG_EF] = ~eblk & ({4'h0, pin_q.neu} > eo_q); // [R13]
      st[`MPS_STG_UB] = uen & (upct > {12'h000, ub_q}); // [R19]
      hold[`MPS_STG_ST] = pin_q.speed; // [R8]
      tgt[`MPS_STG_ST] = ts_q;
      tgt[`MPS_STG_HS] = hst_q;
      tgt[`MPS_STG_EF] = eot_q;
      tgt[`MPS_STG_UB] = utgt[19:0];
   end

   // thermal stress accumulation for start-up supervision
   assign sq = {16'h0000, imax} * {16'h0000, imax};
   assign lim = {40'h0, is_q} * {40'h0, is_q} * {40'h0, ts_q}; // [R2]
   assign acc_run = sw_q.startup_mode_select & st[`MPS_STG_ST] &
                    (sw_q.stress_count_start_opt | (ss_q == SS_START)); // [R2]

   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
         acc_q <= '0;
      else if (!acc_run)
         acc_q <= '0; // [R24]
      else if (tick_q && !pin_q.speed)
         acc_q <= acc_q + {28'h0, sq}; // [R1] [R8]

   // stage timers
   for (genvar i = 0; i < `MPS_NSTG; i++)
   begin : g_tmr
      always_ff @(posedge sys_clk or posedge rst)
         if (rst)
            tmr_q[i] <= '0;
         else if (!st[i])
            tmr_q[i] <= '0; // [R24]
         else if (tick_q && !hold[i] && tmr_q[i] < tgt[i])
            tmr_q[i] <= tmr_q[i] + 20'h1; // [R8] [R24]
   end

   always_comb
   begin
      for (int i = 0; i < `MPS_NSTG; i++)
         op[i] = st[i] && tmr_q[i] >= tgt[i]; // [R9] [R13] [R19]
      if (sw_q.startup_mode_select)
         op[`MPS_STG_ST] = acc_run && acc_q > lim; // [R2]
      lat = {`MPS_NSTG{sw_q.latch_opt_a}}; // [R6]
      lat[`MPS_STG_HS] = sw_q.latch_opt_a | sw_q.latch_opt_b;
      lat[`MPS_STG_EF] = sw_q.latch_opt_a | sw_q.latch_opt_b;
      ind_set = op;
      ind_set[`MPS_STG_EF] = op[`MPS_STG_EF] | (st[`MPS_STG_EF] & ~sw_q.earth_trip_route); // [R14]
   end

   // trip latches and indicators, set wins over clear
   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
      begin
         tr_q <= '0;
         ind_q <= '0;
      end
      else
      begin
         tr_q <= op | (lat & tr_q & {`MPS_NSTG{~trip_clr}}); // [R6] [R7]
         ind_q <= ind_set | (ind_q & {`MPS_NSTG{~ind_clr}}); // [R4] [R9] [R13] [R20]
      end

   // display code of the latest start-up, earth or unbalance operation, in that priority
   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
         display_code <= '0;
      else if (op[`MPS_STG_ST])
         display_code <= `MPS_DISP_ST; // [R4]
      else if (op[`MPS_STG_EF])
         display_code <= `MPS_DISP_EF; // [R13]
      else if (op[`MPS_STG_UB])
         display_code <= `MPS_DISP_UB; // [R20]
      else if (ind_clr)
         display_code <= '0;

   // recorded trip count, erased by erasing resets
   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
         trips_q <= '0;
      else if (|(op & ~tr_q))
         trips_q <= trips_q + 8'h01;
      else if (rst_erase)
         trips_q <= '0; // [R7]

   // relay and panel outputs
   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
      begin
         signal_out_one <= 1'b0;
         signal_out_two <= 1'b0;
         signal_out_three <= 1'b0;
         trip_out_one <= 1'b0;
         trip_out_two <= 1'b0;
         stage_start <= '0;
         indicator <= '0;
      end
      else
      begin
         signal_out_one <= st[`MPS_STG_ST] & sw_q.start_route_sel; // [R3]
         signal_out_two <= (tr_q[`MPS_STG_HS] & sw_q.hs_to_ss2) | tr_q[`MPS_STG_EF]; // [R10] [R14]
         signal_out_three <= tr_q[`MPS_STG_HS]; // [R10]
         trip_out_one <= tr_q[`MPS_STG_ST] | tr_q[`MPS_STG_HS] | tr_q[`MPS_STG_UB]; // [R20]
         trip_out_two <= tr_q[`MPS_STG_EF] & sw_q.earth_trip_route; // [R14]
         stage_start <= st;
         indicator <= ind_q;
      end

   // register read, data in the cycle after the strobe only
   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
         rdata <= '0;
      else if (!rd)
         rdata <= '0;
      else
      begin
         case (addr)
            `MPS_A_SW: rdata <= {18'h0, sw_q};
            `MPS_A_FLC: rdata <= {16'h0, flc_q};
            `MPS_A_IS: rdata <= {12'h0, is_q};
            `MPS_A_TS: rdata <= {12'h0, ts_q};
            `MPS_A_HS: rdata <= {12'h0, hs_q};
            `MPS_A_HST: rdata <= {12'h0, hst_q};
            `MPS_A_EO: rdata <= {12'h0, eo_q};
            `MPS_A_EOT: rdata <= {12'h0, eot_q};
            `MPS_A_UB: rdata <= {12'h0, ub_q};
            `MPS_A_UBT: rdata <= {12'h0, ubt_q};
            `MPS_A_STAT: rdata <= {12'h0, ~uen, sw_q.highset_disable, ss_q == SS_START, pin_q.speed,
                                   display_code, tr_q, ind_q, st}; // [R9] [R22]
            `MPS_A_REC: rdata <= {24'h0, trips_q};
            default: rdata <= '0;
         endcase
      end

   // checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   sequence s_rise;
      ss_q == SS_RISE && rise;
   endsequence

   sequence s_in_start;
      ss_q == SS_START;
   endsequence

   start_sit_a: assert property (s_rise |=> s_in_start) // [R12]
      else $error("starting situation not entered");
   hs_dash_a: assert property (sw_q.highset_disable |-> !st[`MPS_STG_HS] && !op[`MPS_STG_HS]) // [R9]
      else $error("disabled high-set stage operated");
   ef_block_a: assert property (sw_q.earth_block_en && pin_q.block |-> !st[`MPS_STG_EF]) // [R15]
      else $error("blocked earth stage started");
   stall_freeze_a: assert property ((pin_q.speed && st[`MPS_STG_ST]) [*2] |-> $stable(tmr_q[`MPS_STG_ST])) // [R8]
      else $error("start-up timer ran under speed switch");
   stall_latch_a: assert property (tr_q[`MPS_STG_ST] && sw_q.latch_opt_a && !trip_clr |=> tr_q[`MPS_STG_ST]) // [R6]
      else $error("latched start-up trip dropped");
   ss3_route_a: assert property (op[`MPS_STG_HS] |-> ##2 signal_out_three) // [R10]
      else $error("high-set trip missing on output three");
   ef_route_a: assert property (!sw_q.earth_trip_route [*2] |-> !trip_out_two) // [R14]
      else $error("signalling earth stage drove trip two");
   disp_stall_a: assert property (op[`MPS_STG_ST] |=> display_code == `MPS_DISP_ST) // [R4]
      else $error("start-up code not shown");
   unbal_ind_a: assert property (ind_q[`MPS_STG_UB] && !ind_clr |=> ind_q[`MPS_STG_UB]) // [R20]
      else $error("unbalance indicator dropped");
   unbal_div_a: assert property (imax < flc_q |-> denom == flc_q) // [R18]
      else $error("unbalance divisor below full load");
   tmr_clear_a: assert property (!st[`MPS_STG_HS] |=> tmr_q[`MPS_STG_HS] == 20'h0) // [R24]
      else $error("high-set timer not cleared");
   rd_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("read data outside read slot");

endmodule // mps_top

// ### verif/mps_meas_model.sv
// model of the phase and neutral current transducers
`timescale 1ns/1ps
module mps_meas_model
(
   // clock
   input wire logic sys_clk,
   // wanted magnitudes
   input wire logic [15:0] set_a,
   input wire logic [15:0] set_b,
   input wire logic [15:0] set_c,
   input wire logic [15:0] set_n,
   // measured magnitudes
   output logic [15:0] cur_a,
   output logic [15:0] cur_b,
   output logic [15:0] cur_c,
   output logic [15:0] cur_n
);
   // magnitudes settle one clock after a change, as a real converter does
   initial {cur_a, cur_b, cur_c, cur_n} = 64'h0;
   always @(posedge sys_clk)
   begin
      {cur_a, cur_b, cur_c, cur_n} <= {set_a, set_b, set_c, set_n};
   end
endmodule // mps_meas_model

// ### verif/test_motor_protection_trip_stages.sv
// self-checking bench for the motor protection stages
`timescale 1ns/1ps
module test_motor_protection_trip_stages;
   import mps_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_p = 1'b0;
   logic [31:0] rdata;
   logic [15:0] set_a = 16'h0, set_b = 16'h0, set_c = 16'h0, set_n = 16'h0;
   logic [15:0] cur_a, cur_b, cur_c, cur_n;
   logic speed_switch = 1'b0, blocking_input = 1'b0, ext_reset_in = 1'b0;
   logic reset_button = 1'b0, program_button = 1'b0, step_button = 1'b0;
   logic so1, so2, so3, to1, to2;
   logic [3:0] stage_start, indicator, display_code;
   logic [16:0] obs;
   logic [31:0] exp_q[$];
   int n_errors = 0;
   int num_checks = 0;
   int seed = 17069;
   assign obs = {display_code, indicator, stage_start, to2, to1, so3, so2, so1};
   initial forever #5 sys_clk = ~sys_clk;
   mps_meas_model meas (.sys_clk(sys_clk), .set_a(set_a), .set_b(set_b), .set_c(set_c), .set_n(set_n),
      .cur_a(cur_a), .cur_b(cur_b), .cur_c(cur_c), .cur_n(cur_n));
   mps_top #(.TICK_CYC(10)) dut (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .phase_a_cur(cur_a), .phase_b_cur(cur_b), .phase_c_cur(cur_c), .neutral_cur(cur_n),
      .speed_switch(speed_switch), .blocking_input(blocking_input), .ext_reset_in(ext_reset_in),
      .reset_button(reset_button), .program_button(program_button), .step_button(step_button),
      .signal_out_one(so1), .signal_out_two(so2), .signal_out_three(so3), .trip_out_one(to1),
      .trip_out_two(to2), .stage_start(stage_start), .indicator(indicator), .display_code(display_code));
   task automatic close_out();
      if (n_errors == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      num_checks++;
      if (seen !== want)
      begin
         n_errors++;
         $display("BAD %0t: got %h want %h", $time, seen, want);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      {addr, wdata, wr} <= {a, d, 1'b1};
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
      @(posedge sys_clk);
      {addr, rd} <= {a, 1'b1};
      exp_q.push_back(want);
      @(posedge sys_clk);
      rd <= 1'b0;
   endtask
   task automatic cur(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c, input logic [15:0] n);
      @(posedge sys_clk);
      {set_a, set_b, set_c, set_n} <= {a, b, c, n};
   endtask
   task automatic press(input int w);
      @(posedge sys_clk);
      if (w == 0)
         reset_button <= 1'b1;
      else
         ext_reset_in <= 1'b1;
      step(4);
      {reset_button, ext_reset_in} <= 2'b00;
      step(4);
   endtask
   task automatic wait_obs(input int sel, input int bound);
      int n;
      n = 0;
      while (obs[sel] !== 1'b1 && n < bound)
      begin
         step(1);
         n++;
      end
      chk(obs[sel], 1'b1);
      if (obs[sel] !== 1'b1)
         close_out();
   endtask
   // read data are compared in the cycle after the read strobe
   always @(posedge sys_clk)
   begin
      if (rd_p)
         chk(rdata, exp_q.pop_front());
      rd_p <= rd;
   end
   initial
   begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      rd_chk(8'h00, 32'h1820);
      rd_chk(8'h08, 32'h258);
      wr_reg(8'h08, 32'h5);
      rd_chk(8'h08, 32'h64);
      wr_reg(8'h0c, 32'h7fffffff);
      rd_chk(8'h0c, 32'h13880);
      wr_reg(8'h10, 32'h1);
      rd_chk(8'h10, 32'h32);
      wr_reg(8'h20, 32'h63);
      rd_chk(8'h20, 32'h28);
      wr_reg(8'h3c, $random(seed));
      rd_chk(8'h3c, 32'h0);
      wr_reg(8'h08, 32'h258);
      wr_reg(8'h10, 32'h3e8);
      wr_reg(8'h20, 32'h14);
      // high-set trip after 100 ticks, then drops without latch
      cur(16'h44c, 16'({$random(seed)} % 900), 16'h0, 16'h0);
      step(900);
      chk(obs[2], 1'b0);
      wait_obs(2, 400);
      step(2);
      chk({to1, so2, indicator[1], stage_start[1]}, 4'hb);
      cur(16'h0, 16'h0, 16'h0, 16'h0);
      step(20);
      chk({to1, so3, indicator[1]}, 3'h1);
      press(0);
      chk(indicator, 4'h0);
      // doubled setting during a starting situation
      wr_reg(8'h00, 32'h1920);
      cur(16'h64, 16'h64, 16'h64, 16'h0);
      cur(16'h44c, 16'h44c, 16'h44c, 16'h0);
      step(100);
      chk(stage_start[1], 1'b0);
      cur(16'h0, 16'h0, 16'h0, 16'h0);
      // earth stage, routed to trip two
      wr_reg(8'h00, 32'h1820);
      wr_reg(8'h1c, 32'h32);
      cur(16'h0, 16'h0, 16'h0, 16'hc8);
      wait_obs(4, 700);
      step(2);
      chk({so2, display_code}, 5'h17);
      cur(16'h0, 16'h0, 16'h0, 16'h0);
      press(0);
      // signalling only
      wr_reg(8'h00, 32'h0820);
      cur(16'h0, 16'h0, 16'h0, 16'hc8);
      wait_obs(1, 700);
      step(2);
      chk({to2, indicator[2]}, 2'h1);
      cur(16'h0, 16'h0, 16'h0, 16'h0);
      press(0);
      // blocked, then inhibited by high phase current
      wr_reg(8'h00, 32'h1822);
      blocking_input <= 1'b1;
      cur(16'h0, 16'h0, 16'h0, 16'hc8);
      step(700);
      chk({stage_start[2], to2}, 2'h0);
      blocking_input <= 1'b0;
      wr_reg(8'h00, 32'h1a20);
      cur(16'h1f4, 16'h1f4, 16'h1f4, 16'hc8);
      step(700);
      chk({stage_start[2], to2}, 2'h0);
      cur(16'h0, 16'h0, 16'h0, 16'h0);
      wr_reg(8'h00, 32'h1820);
      press(0);
      // full single-phasing trips after about one second
      cur(16'h64, 16'h64, 16'h0, 16'h0);
      step(9000);
      chk(obs[3], 1'b0);
      wait_obs(3, 2500);
      step(2);
      chk({indicator[3], display_code}, 5'h15);
      cur(16'h0, 16'h0, 16'h0, 16'h0);
      press(0);
      // latched trip held until the keep-data command
      wr_reg(8'h00, 32'h3828);
      cur(16'h44c, 16'h44c, 16'h44c, 16'h0);
      wait_obs(3, 1400);
      cur(16'h0, 16'h0, 16'h0, 16'h0);
      step(30);
      chk(to1, 1'b1);
      chk(so2, 1'b1);
      wr_reg(8'h28, 32'h1);
      step(5);
      chk(to1, 1'b0);
      press(1);
      rd_chk(8'h30, 32'h0);
      // thermal start-up supervision, frozen by the speed switch
      wr_reg(8'h0c, 32'h12c);
      wr_reg(8'h00, 32'h18f8);
      speed_switch <= 1'b1;
      cur(16'h44c, 16'h44c, 16'h44c, 16'h0);
      step(1500);
      chk({to1, stage_start[0]}, 2'h1);
      chk(so1, 1'b1);
      speed_switch <= 1'b0;
      step(800);
      chk(to1, 1'b0);
      wait_obs(3, 600);
      step(2);
      chk({indicator[0], display_code}, 5'h16);
      cur(16'h0, 16'h0, 16'h0, 16'h0);
      step(20);
      chk(to1, 1'b1);
      step(5);
      close_out();
   end
endmodule // test_motor_protection_trip_stages
